/* File: dv/tb_abao_alu.sv */
`timescale 1ns/10ps
module tb_abao_alu;
	import abao_pkg::*;

	// ****************************************************
	// Stimulus signals and counters
	// ****************************************************
	logic clock;
	logic sys_rst;
	logic op_valid;
	abao_req_s op_req;
	logic [6:0] bus_addr;
	logic [7:0] bus_wdata;
	logic bus_wr;
	logic bus_rd;
	logic [7:0] bus_rdata;
	logic [7:0] accumulator;
	abao_flags_s flags;
	logic op_done;
	int error_cnt;
	int samples_checked;
	int cycles;
	logic [7:0] rdv;

	abao_alu i_abao_alu (
		.clock(clock),
		.sys_rst(sys_rst),
		.op_valid(op_valid),
		.op_req(op_req),
		.bus_addr(bus_addr),
		.bus_wdata(bus_wdata),
		.bus_wr(bus_wr),
		.bus_rd(bus_rd),
		.bus_rdata(bus_rdata),
		.accumulator(accumulator),
		.flags(flags),
		.op_done(op_done)
	);

	always #25 clock = ~clock;

	// The ceiling is well above the few hundred cycles the run needs.
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			error_cnt++;
			end_sim();
		end
	end

	// ****************************************************
	// Access tasks
	// ****************************************************
	task end_sim();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	task wr(input logic [6:0] ad, input logic [7:0] d);
		@(posedge clock);
		bus_addr <= ad;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge clock);
		bus_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe.
	task rd(input logic [6:0] ad, output logic [7:0] d);
		@(posedge clock);
		bus_addr <= ad;
		bus_rd <= 1'b1;
		@(posedge clock);
		bus_rd <= 1'b0;
		#1;
		d = bus_rdata;
	endtask

	task do_case(input logic [7:0] a, input logic [5:0] ri,
		input logic [7:0] rv, input logic [2:0] st, input abao_op_e op,
		input logic d, input logic [2:0] bs, input logic [7:0] im,
		input logic [7:0] ea, input logic [7:0] er, input logic [2:0] ef);
		wr(7'h40, a);
		wr({1'b0, ri}, rv);
		wr(7'h41, {5'h00, st});
		@(posedge clock);
		op_valid <= 1'b1;
		op_req <= '{op: op, raddr: ri, dest: d, bitsel: bs, imm: im};
		@(posedge clock);
		op_valid <= 1'b0;
		#1;
		chk("op_done", 8'h01, {7'h00, op_done});
		chk("accumulator", ea, accumulator);
		chk("flags", {5'h00, ef}, {5'h00, flags});
		@(posedge clock);
		#1;
		chk("op_done low", 8'h00, {7'h00, op_done});
		rd({1'b0, ri}, rdv);
		chk("register", er, rdv);
		rd(7'h41, rdv);
		chk("status", {5'h00, ef}, rdv);
	endtask

	// ****************************************************
	// Test sequence
	// ****************************************************
	initial begin
		clock = 1'b0;
		sys_rst = 1'b1;
		op_valid = 1'b0;
		op_req = '0;
		bus_addr = 7'h00;
		bus_wdata = 8'h00;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		error_cnt = 0;
		samples_checked = 0;
		cycles = 0;
		repeat (10) @(posedge clock);
		sys_rst <= 1'b0;
		rd(7'h40, rdv);
		chk("reset accumulator", 8'h00, rdv);
		rd(7'h41, rdv);
		chk("reset status", 8'h00, rdv);
		do_case(8'h12, 6'h05, 8'h34, 3'h1, op_add_reg_with_carry, 1'b1, 3'h0,
			8'h00, 8'h12, 8'h47, 3'h0);
		do_case(8'h0F, 6'h3F, 8'h00, 3'h1, op_add_reg_with_carry, 1'b0, 3'h0,
			8'h00, 8'h10, 8'h00, 3'h2);
		do_case(8'hF0, 6'h01, 8'h10, 3'h1, op_add_reg_with_carry, 1'b0, 3'h0,
			8'h00, 8'h01, 8'h10, 3'h1);
		do_case(8'h12, 6'h05, 8'h34, 3'h1, op_add_reg, 1'b1, 3'h0,
			8'h00, 8'h12, 8'h46, 3'h0);
		do_case(8'hFF, 6'h00, 8'h01, 3'h1, op_add_reg, 1'b0, 3'h0,
			8'h00, 8'h00, 8'h01, 3'h7);
		do_case(8'hF8, 6'h07, 8'h77, 3'h1, op_add_imm_with_carry, 1'b1, 3'h0,
			8'h08, 8'h01, 8'h77, 3'h3);
		do_case(8'h80, 6'h07, 8'h77, 3'h1, op_add_imm, 1'b1, 3'h0,
			8'h80, 8'h00, 8'h77, 3'h5);
		do_case(8'h12, 6'h07, 8'h77, 3'h1, op_add_imm, 1'b0, 3'h0,
			8'h34, 8'h46, 8'h77, 3'h0);
		do_case(8'h5A, 6'h09, 8'hAF, 3'h3, op_and_reg, 1'b1, 3'h0,
			8'h00, 8'h5A, 8'h0A, 3'h3);
		do_case(8'h0F, 6'h09, 8'hF0, 3'h0, op_and_reg, 1'b0, 3'h0,
			8'h00, 8'h00, 8'hF0, 3'h4);
		do_case(8'h5A, 6'h09, 8'h11, 3'h3, op_and_imm, 1'b1, 3'h0,
			8'hA5, 8'h00, 8'h11, 3'h7);
		do_case(8'h5A, 6'h09, 8'h11, 3'h4, op_and_imm, 1'b0, 3'h0,
			8'hAF, 8'h0A, 8'h11, 3'h0);
		do_case(8'h33, 6'h21, 8'h5A, 3'h5, op_bit_clear, 1'b0, 3'h3,
			8'hFF, 8'h33, 8'h52, 3'h5);
		do_case(8'h33, 6'h21, 8'h5A, 3'h2, op_bit_set, 1'b0, 3'h2,
			8'h00, 8'h33, 8'h5E, 3'h2);
		for (int b = 0; b < 8; b++) begin
			do_case(8'h00, 6'h10, 8'hFF, 3'h7, op_bit_clear, 1'b1, b[2:0],
				8'h00, 8'h00, 8'hFF ^ (8'h01 << b), 3'h7);
			do_case(8'hFF, 6'h11, 8'h00, 3'h0, op_bit_set, 1'b1, b[2:0],
				8'h00, 8'hFF, 8'h01 << b, 3'h0);
		end
		wr(7'h12, 8'h0F);
		@(posedge clock);
		op_valid <= 1'b1;
		op_req <= '{op: op_bit_set, raddr: 6'h12, dest: 1'b0, bitsel: 3'h7,
			imm: 8'h00};
		@(posedge clock);
		op_req.op <= op_bit_clear;
		op_req.bitsel <= 3'h0;
		@(posedge clock);
		op_valid <= 1'b0;
		rd(7'h12, rdv);
		chk("chained bits", 8'h8E, rdv);
		@(posedge clock);
		#1;
		chk("rdata idle", 8'h00, bus_rdata);
		wr(7'h50, 8'hA5);
		rd(7'h50, rdv);
		chk("unmapped", 8'h00, rdv);
		end_sim();
	end
endmodule

/* File: hdl/abao_alu.sv */
`timescale 1ns/10ps
// Summary of operation
// - Register add with carry, flags, one cycle.
// - Destination bit 0 to accumulator, 1 register.
// - Register add ignores carry-in, updates three flags.
// - Immediate add with carry, result to accumulator.
// - Immediate add without carry into accumulator.
// - Register AND, only zero flag changes.
// - Immediate AND into accumulator, zero flag only.
// - Bit clear forces one register bit low.
// - Bit set forces one register bit high.
// - Carry flag equals carry out of bit 7.
module abao_alu #(
	parameter int REG_COUNT = abao_pkg::ABAO_REG_COUNT
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic op_valid,
	input wire abao_pkg::abao_req_s op_req,
	input wire logic [abao_pkg::ABAO_BADDR_W-1:0] bus_addr,
	input wire logic [abao_pkg::ABAO_DATA_W-1:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [abao_pkg::ABAO_DATA_W-1:0] bus_rdata,
	output logic [abao_pkg::ABAO_DATA_W-1:0] accumulator,
	output abao_pkg::abao_flags_s flags,
	output logic op_done
);
	import abao_pkg::*;

	// ****************************************************
	// Parameter check
	// ****************************************************
	if (REG_COUNT < 1 || REG_COUNT > ABAO_REG_COUNT) begin : g_chk
		$error("REG_COUNT must lie between 1 and 64.");
	end

	// ****************************************************
	// Adder shared by all four additions
	// ****************************************************
	// Returns {carry, digit carry, sum}.
	function automatic logic [9:0] alu_add(input logic [7:0] a,
		input logic [7:0] b, input logic cin);
		logic [4:0] lo;
		logic [4:0] hi;
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
		return {hi[4], lo[4], hi[3:0], lo[3:0]};
	endfunction

	logic [7:0] rf_ff [REG_COUNT];
	logic [7:0] nxt_rf [REG_COUNT];
	logic [7:0] acc_ff;
	logic [7:0] nxt_acc;
	abao_flags_s flg_ff;
	abao_flags_s nxt_flg;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;
	logic done_ff;
	logic nxt_done;
	logic [7:0] rf_rd;
	logic [7:0] opnd_b;
	logic add_cin;
	logic [9:0] add_res;
	logic [7:0] and_res;
	logic [7:0] bit_mask;
	logic bus_rf_hit;

	assign rf_rd = (int'(op_req.raddr) < REG_COUNT) ?
		rf_ff[op_req.raddr] : ABAO_RST_DATA;
	assign bus_rf_hit = (bus_addr < ABAO_OFS_ACC) &&
		(int'(bus_addr) < REG_COUNT);

	// ****************************************************
	// Operand selection
	// ****************************************************
	always_comb begin
		opnd_b = rf_rd;
		add_cin = 1'b0;
		unique case (op_req.op)
			op_add_reg_with_carry: begin
				add_cin = flg_ff.carry;
			end
			op_add_reg: begin
				add_cin = 1'b0;
			end
			op_add_imm_with_carry: begin
				opnd_b = op_req.imm;
				add_cin = flg_ff.carry;
			end
			op_add_imm, op_and_imm: begin
				opnd_b = op_req.imm;
			end
			op_and_reg, op_bit_clear, op_bit_set: begin
				opnd_b = rf_rd;
			end
		endcase
		add_res = alu_add(acc_ff, opnd_b, add_cin);
		and_res = acc_ff & opnd_b;
		bit_mask = 8'h01 << op_req.bitsel;
	end

	// ****************************************************
	// Next state of accumulator, flags and register file
	// ****************************************************
	// A bus write and an operation in the same cycle both land; when
	// they hit the same byte the operation wins, since it is assigned after
	// the write; in the status byte it replaces only the flags it updates.
	always_comb begin
		nxt_rf = rf_ff;
		nxt_acc = acc_ff;
		nxt_flg = flg_ff;
		nxt_done = 1'b0;
		nxt_rdata = ABAO_RD_UNMAPPED;
		if (bus_wr) begin
			if (bus_rf_hit) begin
				nxt_rf[bus_addr[5:0]] = bus_wdata;
			end else if (bus_addr == ABAO_OFS_ACC) begin
				nxt_acc = bus_wdata;
			end else if (bus_addr == ABAO_OFS_STATUS) begin
				nxt_flg.carry = bus_wdata[ABAO_STAT_CARRY];
				nxt_flg.digit_carry_flag = bus_wdata[ABAO_STAT_DC];
				nxt_flg.zero = bus_wdata[ABAO_STAT_ZERO];
			end
		end
		if (bus_rd) begin
			if (bus_rf_hit) begin
				nxt_rdata = rf_ff[bus_addr[5:0]];
			end else if (bus_addr == ABAO_OFS_ACC) begin
				nxt_rdata = acc_ff;
			end else if (bus_addr == ABAO_OFS_STATUS) begin
				nxt_rdata[ABAO_STAT_CARRY] = flg_ff.carry;
				nxt_rdata[ABAO_STAT_DC] = flg_ff.digit_carry_flag;
				nxt_rdata[ABAO_STAT_ZERO] = flg_ff.zero;
			end
		end
		if (op_valid) begin
			nxt_done = 1'b1;
			unique case (op_req.op)
				op_add_reg_with_carry, op_add_reg: begin
					if (op_req.dest) begin
						nxt_rf[op_req.raddr] = add_res[7:0];
					end else begin
						nxt_acc = add_res[7:0];
					end
					nxt_flg.carry = add_res[9];
					nxt_flg.digit_carry_flag = add_res[8];
					nxt_flg.zero = (add_res[7:0] == 8'h00);
				end
				op_add_imm_with_carry, op_add_imm: begin
					nxt_acc = add_res[7:0];
					nxt_flg.carry = add_res[9];
					nxt_flg.digit_carry_flag = add_res[8];
					nxt_flg.zero = (add_res[7:0] == 8'h00);
				end
				op_and_reg: begin
					if (op_req.dest) begin
						nxt_rf[op_req.raddr] = and_res;
					end else begin
						nxt_acc = and_res;
					end
					nxt_flg.zero = (and_res == 8'h00);
				end
				op_and_imm: begin
					nxt_acc = and_res;
					nxt_flg.zero = (and_res == 8'h00);
				end
				op_bit_clear: begin
					nxt_rf[op_req.raddr] = rf_rd & ~bit_mask;
				end
				op_bit_set: begin
					nxt_rf[op_req.raddr] = rf_rd | bit_mask;
				end
			endcase
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				rf_ff[i] <= ABAO_RST_DATA;
			end
			acc_ff <= ABAO_RST_DATA;
			flg_ff <= '0;
			rdata_ff <= ABAO_RST_DATA;
			done_ff <= 1'b0;
		end else begin
			rf_ff <= nxt_rf;
			acc_ff <= nxt_acc;
			flg_ff <= nxt_flg;
			rdata_ff <= nxt_rdata;
			done_ff <= nxt_done;
		end
	end

	assign bus_rdata = rdata_ff;
	assign accumulator = acc_ff;
	assign flags = flg_ff;
	assign op_done = done_ff;

	// ****************************************************
	// Checks
	// ****************************************************
	// Helper values captured in the issue cycle; only the checks use them.
	logic [8:0] chk_sum_c;
	logic [8:0] chk_sum_nc;
	logic [7:0] chk_rf_now;
	logic [4:0] chk_lo_nc;
	logic chk_op_quiet;
	assign chk_sum_c = {1'b0, acc_ff} + {1'b0, opnd_b} +
		{8'h00, flg_ff.carry};
	assign chk_sum_nc = {1'b0, acc_ff} + {1'b0, opnd_b};
	assign chk_lo_nc = {1'b0, acc_ff[3:0]} + {1'b0, opnd_b[3:0]};
	assign chk_rf_now = rf_rd;
	assign chk_op_quiet = op_valid && !bus_wr;
	// The target register is indexed by the request of the issue cycle,
	// because the request may already carry the next operation.

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	AST_ADC_REG: assert property (
		chk_op_quiet && op_req.op == op_add_reg_with_carry && !op_req.dest
		|=> {flg_ff.carry, acc_ff} == $past(chk_sum_c) && op_done)
		else $error("Register add with carry gave a wrong sum.");
	AST_DEST_REG: assert property (
		chk_op_quiet && op_req.op == op_add_reg && op_req.dest
		|=> rf_ff[$past(op_req.raddr)] == $past(chk_sum_nc[7:0]) &&
			acc_ff == $past(acc_ff))
		else $error("Destination one did not write the register.");
	AST_ADD_REG: assert property (
		chk_op_quiet && op_req.op == op_add_reg && !op_req.dest
		|=> {flg_ff.carry, acc_ff} == $past(chk_sum_nc))
		else $error("Register add without carry gave a wrong sum.");
	AST_ADC_IMM: assert property (
		chk_op_quiet && op_req.op == op_add_imm_with_carry
		|=> {flg_ff.carry, acc_ff} == $past(chk_sum_c))
		else $error("Immediate add with carry gave a wrong sum.");
	AST_ADD_IMM: assert property (
		chk_op_quiet && op_req.op == op_add_imm
		|=> acc_ff == $past(chk_sum_nc[7:0]))
		else $error("Immediate add gave a wrong sum.");
	AST_AND_REG: assert property (
		chk_op_quiet && op_req.op == op_and_reg && !op_req.dest
		|=> acc_ff == ($past(acc_ff) & $past(chk_rf_now)) &&
			flg_ff.carry == $past(flg_ff.carry) &&
			$stable(flg_ff.digit_carry_flag))
		else $error("Register AND was wrong or touched carry flags.");
	AST_AND_IMM: assert property (
		chk_op_quiet && op_req.op == op_and_imm
		|=> acc_ff == ($past(acc_ff) & $past(op_req.imm)) &&
			flg_ff.zero == (acc_ff == 8'h00) && $stable(flg_ff.carry))
		else $error("Immediate AND zero flag is wrong.");
	AST_BIT_CLR: assert property (
		chk_op_quiet && op_req.op == op_bit_clear
		|=> rf_ff[$past(op_req.raddr)] ==
			($past(chk_rf_now) & ~$past(bit_mask)) &&
			$stable(flg_ff))
		else $error("Bit clear changed the wrong bits or a flag.");
	AST_BIT_SET: assert property (
		chk_op_quiet && op_req.op == op_bit_set
		|=> rf_ff[$past(op_req.raddr)] ==
			($past(chk_rf_now) | $past(bit_mask)) &&
			$stable(flg_ff))
		else $error("Bit set changed the wrong bits or a flag.");
	AST_ZERO_DC: assert property (
		chk_op_quiet && op_req.op == op_add_imm
		|=> flg_ff.zero == (acc_ff == 8'h00) &&
			flg_ff.digit_carry_flag == $past(chk_lo_nc[4]))
		else $error("Zero or digit carry flag is wrong after an add.");
	AST_CARRY_IMM: assert property (
		chk_op_quiet && op_req.op == op_add_imm
		|=> flg_ff.carry == $past(chk_sum_nc[8]))
		else $error("Carry flag does not match the carry out of bit 7.");
	AST_ZERO_REG: assert property (
		chk_op_quiet && op_req.op == op_add_reg && !op_req.dest
		|=> flg_ff.zero == (acc_ff == 8'h00))
		else $error("Zero flag is wrong after a register add.");
	AST_AND_DEST: assert property (
		chk_op_quiet && op_req.op == op_and_reg && op_req.dest
		|=> rf_ff[$past(op_req.raddr)] ==
			($past(acc_ff) & $past(chk_rf_now)) &&
			acc_ff == $past(acc_ff))
		else $error("Register AND with destination one went astray.");
	AST_DONE: assert property (
		op_done == $past(op_valid))
		else $error("Done pulse does not follow the issue strobe.");
	AST_RD_IDLE: assert property (
		!$past(bus_rd) |-> bus_rdata == 8'h00)
		else $error("Read data is not zero outside its cycle.");

	// ****************************************************
	// Coverage
	// ****************************************************
	COV_DC_OUT: cover property (
		op_valid && op_req.op == op_add_reg_with_carry
		##1 flg_ff.digit_carry_flag);
	COV_ADC_CARRY: cover property (
		op_valid && op_req.op == op_add_reg_with_carry && flg_ff.carry
		##1 flg_ff.carry);
	COV_DEST_REG: cover property (
		op_valid && op_req.dest && op_req.op == op_and_reg);
	COV_BIT_SEQ: cover property (
		op_valid && op_req.op == op_bit_set
		##1 op_valid && op_req.op == op_bit_clear);
	COV_ZERO_AND: cover property (
		op_valid && op_req.op == op_and_imm ##1 flg_ff.zero);

endmodule

/* File: hdl/abao_pkg.sv */
package abao_pkg;

	// ****************************************************
	// Sizes and register map
	// ****************************************************
	localparam int ABAO_DATA_W = 8;
	localparam int ABAO_RIDX_W = 6;
	localparam int ABAO_BADDR_W = 7;
	localparam int ABAO_REG_COUNT = 64;
	localparam logic [6:0] ABAO_OFS_RF_BASE = 7'h00;
	localparam logic [6:0] ABAO_OFS_ACC = 7'h40;
	localparam logic [6:0] ABAO_OFS_STATUS = 7'h41;
	localparam int ABAO_STAT_CARRY = 0;
	localparam int ABAO_STAT_DC = 1;
	localparam int ABAO_STAT_ZERO = 2;
	localparam logic [7:0] ABAO_RST_DATA = 8'h00;
	localparam logic [7:0] ABAO_RD_UNMAPPED = 8'h00;
	localparam int ABAO_OP_CYCLES = 1;

	// ****************************************************
	// Operations and carriers
	// ****************************************************
	typedef enum logic [2:0] {
		op_add_reg_with_carry = 3'h0,
		op_add_reg = 3'h1,
		op_add_imm_with_carry = 3'h2,
		op_add_imm = 3'h3,
		op_and_reg = 3'h4,
		op_and_imm = 3'h5,
		op_bit_clear = 3'h6,
		op_bit_set = 3'h7
	} abao_op_e;

	typedef struct packed {
		abao_op_e op;
		logic [5:0] raddr;
		logic dest;
		logic [2:0] bitsel;
		logic [7:0] imm;
	} abao_req_s;

	typedef struct packed {
		logic zero;
		logic digit_carry_flag;
		logic carry;
	} abao_flags_s;

endpackage
